// [src/adc_power_reset_control.sv]
// Converter control: AHB-Lite registers, power modes, freeze, resets and result storage
`timescale 1ns/1ps
`default_nettype none
`include "adc_power_reset_control_params.svh"
module adc_power_reset_control
  import adc_power_reset_control_pkg::*;
#(
  parameter int CONV_TADS = `CONV_TAD_COUNT,
  parameter int RC_DIV = `RC_DIV_CYCLES
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic external_pin_reset,
  input wire logic watchdog_reset_source,
  input wire logic sleep_mode,
  input wire logic idle_mode,
  input wire logic debug_mode,
  input wire logic conv_irq_enable,
  input wire logic [9:0] analog_code,
  output logic conv_irq_flag_set,
  output logic wake_request,
  output logic conv_clk_run,
  output logic conv_busy,
  output logic [31:0] analog_pin_select
);
  ctl_st_s s_r;
  ctl_st_s s_nxt;

  logic sync_clr;
  logic freeze;
  logic run;
  logic rc_sel;
  logic sys_pulse;
  logic rc_pulse;
  logic clk_en;
  logic addr_ok;
  logic seq_busy;
  logic seq_sample_end;
  logic seq_done;
  logic [9:0] seq_result;
  logic mem_wr;
  logic mem_rd;
  logic [31:0] mem_rdata;

  function automatic logic is_ctrl(input logic [7:0] ofs);
    is_ctrl = (ofs == `OFS_CONTROL_REG_ONE) || (ofs == `OFS_CONTROL_REG_TWO) ||
              (ofs == `OFS_CONTROL_REG_THREE) || (ofs == `OFS_INPUT_SELECT_REG) ||
              (ofs == `OFS_ANALOG_PIN_SELECT) || (ofs == `OFS_SCAN_SELECT_REG);
  endfunction

  function automatic logic is_buf(input logic [7:0] ofs);
    is_buf = (ofs[7:6] == 2'(`OFS_RESULT_BUFFER >> 6)) && (ofs[1:0] == 2'b00);
  endfunction

  // Stores a write to a control register; the freeze bit lives elsewhere
  function automatic ctl_st_s apply_write(input ctl_st_s st, input logic [7:0] ofs, input logic [31:0] d);
    ctl_st_s r;
    r = st;
    case (ofs)
      `OFS_CONTROL_REG_ONE: begin
        r.one = d;
        r.one[`ONE_FREEZE_BIT] = 1'b0;
        if (!d[`ONE_ON_BIT]) begin
          r.halted = 1'b0;
        end
      end
      `OFS_CONTROL_REG_TWO: r.two = d;
      `OFS_CONTROL_REG_THREE: r.three = d;
      `OFS_INPUT_SELECT_REG: r.chs = d;
      `OFS_ANALOG_PIN_SELECT: r.pcfg = d;
      `OFS_SCAN_SELECT_REG: r.cssl = d;
      default: r = st;
    endcase
    apply_write = r;
  endfunction

  assign sync_clr = external_pin_reset | watchdog_reset_source;
  assign freeze = debug_mode & s_r.frz_act;
  assign rc_sel = s_r.three[`THREE_RC_BIT];

  // Converter runs only when on, not halted, and not stopped by IDLE, SLEEP or freeze
  assign run = s_r.one[`ONE_ON_BIT] & ~s_r.halted
             & ~(idle_mode & s_r.one[`ONE_STOP_IDLE_BIT])
             & ~(sleep_mode & ~rc_sel)
             & ~freeze;

  assign sys_pulse = (s_r.tad_cnt == s_r.three[`THREE_DIV_HI:`THREE_DIV_LO]);
  assign rc_pulse = (s_r.rc_cnt == 8'(RC_DIV - 1));
  assign clk_en = run & (rc_sel ? rc_pulse : (sys_pulse & ~sleep_mode));
  assign conv_clk_run = run & (rc_sel | ~sleep_mode);

  assign addr_ok = hsel & htrans[1] & hready;
  assign mem_rd = addr_ok & ~hwrite;
  assign mem_wr = seq_done & ~sync_clr;

  conv_sequencer #(
    .CONV_TADS(CONV_TADS)
  ) u_seq (
    .hclk(hclk),
    .hresetn(hresetn),
    .clear(sync_clr),
    .enable(run),
    .clk_en(clk_en),
    .samp_req(s_r.one[`ONE_SAMPLE_BIT]),
    .auto_sample(s_r.one[`ONE_AUTO_SAMPLE_BIT]),
    .auto_convert(s_r.one[`ONE_TRIG_HI:`ONE_TRIG_LO] == `TRIG_AUTO),
    .samp_tads(s_r.three[`THREE_SAMP_HI:`THREE_SAMP_LO]),
    .sample_code(s_r.code_s2),
    .busy(seq_busy),
    .sample_end(seq_sample_end),
    .done(seq_done),
    .result(seq_result)
  );

  result_buffer_mem #(
    .WORDS(`RESULT_WORDS),
    .AW(4)
  ) u_buf (
    .hclk(hclk),
    .hresetn(hresetn),
    .clear(sync_clr),
    .wr_en(mem_wr),
    .waddr(s_r.smp_cnt),
    .wdata({22'h0, seq_result}),
    .rd_en(mem_rd),
    .raddr(haddr[5:2]),
    .rdata(mem_rdata)
  );

  always_comb begin
    s_nxt = s_r;
    s_nxt.wake = 1'b0;
    s_nxt.irq_evt = 1'b0;
    s_nxt.code_s1 = analog_code;
    s_nxt.code_s2 = s_r.code_s1;
    s_nxt.dbg_q = debug_mode;
    s_nxt.frz_q = freeze;

    // Clock dividers advance only while the converter runs
    if (run) begin
      s_nxt.tad_cnt = sys_pulse ? 8'h00 : s_r.tad_cnt + 8'h01;
      s_nxt.rc_cnt = rc_pulse ? 8'h00 : s_r.rc_cnt + 8'h01;
    end else begin
      s_nxt.tad_cnt = 8'h00;
      s_nxt.rc_cnt = 8'h00;
    end

    // Freeze value written in debug takes hold at the next debug entry
    if (debug_mode && !s_r.dbg_q) begin
      s_nxt.frz_act = s_r.frz_pend;
    end

    // Address phase; reads take one wait cycle
    if (addr_ok) begin
      s_nxt.a_ofs = haddr[7:0];
      s_nxt.wr_act = hwrite & (hsize == 3'b010);
      s_nxt.rd_act = ~hwrite;
    end else begin
      s_nxt.wr_act = 1'b0;
      if (s_r.rd_act) begin
        s_nxt.rd_act = 1'b0;
      end
    end

    // Read data, registers stay readable during freeze
    if (s_r.rd_act) begin
      s_nxt.hrdata = 32'h0000_0000;
      case (s_r.a_ofs)
        `OFS_CONTROL_REG_ONE: begin
          s_nxt.hrdata = s_r.one;
          s_nxt.hrdata[`ONE_FREEZE_BIT] = debug_mode & s_r.frz_act;
        end
        `OFS_CONTROL_REG_TWO: s_nxt.hrdata = s_r.two;
        `OFS_CONTROL_REG_THREE: s_nxt.hrdata = s_r.three;
        `OFS_INPUT_SELECT_REG: s_nxt.hrdata = s_r.chs;
        `OFS_ANALOG_PIN_SELECT: s_nxt.hrdata = s_r.pcfg;
        `OFS_SCAN_SELECT_REG: s_nxt.hrdata = s_r.cssl;
        default: begin
          if (is_buf(s_r.a_ofs)) begin
            s_nxt.hrdata = mem_rdata;
          end
        end
      endcase
    end

    // Held write lands when freeze ends
    if (s_r.frz_q && !freeze && s_r.held_v) begin
      s_nxt = apply_write(s_nxt, s_r.held_ofs, s_r.held_data);
      s_nxt.held_v = 1'b0;
    end

    // Write data phase
    if (s_r.wr_act && is_ctrl(s_r.a_ofs)) begin
      if (s_r.a_ofs == `OFS_CONTROL_REG_ONE && debug_mode) begin
        s_nxt.frz_pend = hwdata[`ONE_FREEZE_BIT];
      end
      if (freeze) begin
        s_nxt.held_v = 1'b1;
        s_nxt.held_ofs = s_r.a_ofs;
        s_nxt.held_data = hwdata;
      end else begin
        s_nxt = apply_write(s_nxt, s_r.a_ofs, hwdata);
      end
    end

    // Automatic trigger ends sampling by hardware
    if (seq_sample_end && s_r.one[`ONE_TRIG_HI:`ONE_TRIG_LO] == `TRIG_AUTO) begin
      s_nxt.one[`ONE_SAMPLE_BIT] = 1'b0;
    end

    // Completion: store result, set done (a pin or watchdog clear in the same cycle wins), count samples
    if (seq_done) begin
      s_nxt.one[`ONE_DONE_BIT] = 1'b1;
      if (s_r.smp_cnt == s_r.two[`TWO_SPI_HI:`TWO_SPI_LO]) begin
        s_nxt.smp_cnt = 4'h0;
        s_nxt.irq_evt = 1'b1;
        s_nxt.wake = conv_irq_enable & (sleep_mode | idle_mode);
      end else begin
        s_nxt.smp_cnt = s_r.smp_cnt + 4'h1;
      end
      if (sleep_mode && !conv_irq_enable) begin
        s_nxt.halted = 1'b1;
      end
    end

    // Pin and watchdog resets clear controls and stop conversion
    if (sync_clr) begin
      s_nxt = '0;
      s_nxt.one = `CTRL_RESET_VALUE;
      s_nxt.pcfg = `CTRL_RESET_VALUE;
      s_nxt.dbg_q = debug_mode;
    end
  end

  // Register state is untouched by SLEEP entry or exit
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign hreadyout = ~s_r.rd_act;
  assign hresp = 1'b0;
  assign hrdata = s_r.hrdata;
  assign conv_irq_flag_set = s_r.irq_evt;
  assign wake_request = s_r.wake;
  assign conv_busy = seq_busy;
  assign analog_pin_select = s_r.pcfg;
endmodule
`default_nettype wire

// [include/adc_power_reset_control_params.svh]
// Constants of the converter control block: offsets, field positions, reset values and timing counts
`ifndef ADC_POWER_RESET_CONTROL_PARAMS_SVH
`define ADC_POWER_RESET_CONTROL_PARAMS_SVH

`define OFS_CONTROL_REG_ONE 8'h00
`define OFS_CONTROL_REG_TWO 8'h04
`define OFS_CONTROL_REG_THREE 8'h08
`define OFS_INPUT_SELECT_REG 8'h0C
`define OFS_ANALOG_PIN_SELECT 8'h10
`define OFS_SCAN_SELECT_REG 8'h14
`define OFS_RESULT_BUFFER 8'h40
`define RESULT_WORDS 16

`define CTRL_RESET_VALUE 32'h0000_0000
`define RESULT_RESET_VALUE 32'h0000_0000

`define ONE_ON_BIT 15
`define ONE_FREEZE_BIT 14
`define ONE_STOP_IDLE_BIT 13
`define ONE_TRIG_HI 7
`define ONE_TRIG_LO 5
`define ONE_AUTO_SAMPLE_BIT 2
`define ONE_SAMPLE_BIT 1
`define ONE_DONE_BIT 0
`define TRIG_AUTO 3'h7
`define TWO_SPI_HI 5
`define TWO_SPI_LO 2
`define THREE_RC_BIT 15
`define THREE_SAMP_HI 12
`define THREE_SAMP_LO 8
`define THREE_DIV_HI 7
`define THREE_DIV_LO 0

`define CONV_TAD_COUNT 12
`define CLK_PERIOD_NS 5
`define RC_PERIOD_NS 250
`define RC_DIV_CYCLES (`RC_PERIOD_NS / `CLK_PERIOD_NS)

`endif

// [include/adc_power_reset_control_pkg.sv]
// Types shared by the converter control block
package adc_power_reset_control_pkg;

  typedef enum logic [2:0] {
    SEQ_IDLE = 3'b001,
    SEQ_SAMPLE = 3'b010,
    SEQ_CONVERT = 3'b100
  } seq_state_e;

  typedef struct packed {
    seq_state_e state;
    logic [5:0] cnt;
    logic [9:0] code;
    logic done;
  } seq_st_s;

  typedef struct packed {
    logic [31:0] one;
    logic [31:0] two;
    logic [31:0] three;
    logic [31:0] chs;
    logic [31:0] pcfg;
    logic [31:0] cssl;
    logic frz_pend;
    logic frz_act;
    logic dbg_q;
    logic frz_q;
    logic halted;
    logic [7:0] tad_cnt;
    logic [7:0] rc_cnt;
    logic [3:0] smp_cnt;
    logic wr_act;
    logic rd_act;
    logic [7:0] a_ofs;
    logic [31:0] hrdata;
    logic held_v;
    logic [7:0] held_ofs;
    logic [31:0] held_data;
    logic [9:0] code_s1;
    logic [9:0] code_s2;
    logic wake;
    logic irq_evt;
  } ctl_st_s;

endpackage

// [src/result_buffer_mem.sv]
// Result buffer memory with registered read data and whole-buffer clear
`timescale 1ns/1ps
`default_nettype none
`include "adc_power_reset_control_params.svh"
module result_buffer_mem #(
  parameter int WORDS = `RESULT_WORDS,
  parameter int AW = 4
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clear,
  input wire logic wr_en,
  input wire logic [AW-1:0] waddr,
  input wire logic [31:0] wdata,
  input wire logic rd_en,
  input wire logic [AW-1:0] raddr,
  output logic [31:0] rdata
);
  typedef struct packed {
    logic [WORDS-1:0][31:0] words;
    logic [31:0] rdata;
  } mem_st_s;

  mem_st_s s_r;
  mem_st_s s_nxt;

  always_comb begin
    s_nxt = s_r;
    if (rd_en) begin
      s_nxt.rdata = s_r.words[raddr];
    end
    if (clear) begin
      s_nxt.words = {WORDS{`RESULT_RESET_VALUE}};
    end else if (wr_en) begin
      s_nxt.words[waddr] = wdata;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign rdata = s_r.rdata;
endmodule
`default_nettype wire

// [src/conv_sequencer.sv]
// Sample and convert sequencer stepping on converter clock enables
`timescale 1ns/1ps
`default_nettype none
`include "adc_power_reset_control_params.svh"
module conv_sequencer
  import adc_power_reset_control_pkg::*;
#(
  parameter int CONV_TADS = `CONV_TAD_COUNT
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clear,
  input wire logic enable,
  input wire logic clk_en,
  input wire logic samp_req,
  input wire logic auto_sample,
  input wire logic auto_convert,
  input wire logic [4:0] samp_tads,
  input wire logic [9:0] sample_code,
  output logic busy,
  output logic sample_end,
  output logic done,
  output logic [9:0] result
);
  seq_st_s s_r;
  seq_st_s s_nxt;

  always_comb begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    sample_end = 1'b0;
    if (clear || !enable) begin
      s_nxt.state = SEQ_IDLE;
      s_nxt.cnt = '0;
    end else begin
      case (s_r.state)
        SEQ_IDLE: begin
          if (samp_req || auto_sample) begin
            s_nxt.state = SEQ_SAMPLE;
            s_nxt.cnt = '0;
          end
        end
        SEQ_SAMPLE: begin
          if (auto_convert) begin
            if (clk_en) begin
              if (s_r.cnt >= {1'b0, samp_tads}) begin
                sample_end = 1'b1;
              end else begin
                s_nxt.cnt = s_r.cnt + 6'h01;
              end
            end
          end else if (!samp_req && !auto_sample) begin
            sample_end = 1'b1;
          end
          if (sample_end) begin
            s_nxt.state = SEQ_CONVERT;
            s_nxt.cnt = '0;
            s_nxt.code = sample_code;
          end
        end
        SEQ_CONVERT: begin
          if (clk_en) begin
            if (s_r.cnt == 6'(CONV_TADS - 1)) begin
              s_nxt.done = 1'b1;
              s_nxt.cnt = '0;
              s_nxt.state = auto_sample ? SEQ_SAMPLE : SEQ_IDLE;
            end else begin
              s_nxt.cnt = s_r.cnt + 6'h01;
            end
          end
        end
        default: begin
          s_nxt.state = SEQ_IDLE;
          s_nxt.cnt = '0;
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_r <= '{state: SEQ_IDLE, cnt: '0, code: '0, done: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign busy = (s_r.state != SEQ_IDLE);
  assign done = s_r.done;
  assign result = s_r.code;
endmodule
`default_nettype wire

// [test/adc_power_reset_control_assertions.sv]
// Port-level checker for the converter control block
`timescale 1ns/1ps
`default_nettype none
module adc_power_reset_control_assertions #(
  parameter int CONV_TADS = 12,
  parameter int RC_DIV = 50
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic external_pin_reset,
  input wire logic watchdog_reset_source,
  input wire logic sleep_mode,
  input wire logic idle_mode,
  input wire logic conv_irq_enable,
  input wire logic conv_irq_flag_set,
  input wire logic wake_request,
  input wire logic conv_clk_run,
  input wire logic conv_busy,
  input wire logic [31:0] analog_pin_select
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  wire logic rst_s = external_pin_reset || watchdog_reset_source;
  wire logic low_pwr = sleep_mode || idle_mode;
  AST_WAKE_FLAG: assert property (wake_request |-> conv_irq_flag_set && conv_irq_enable)
    else $error("wake without enabled flag");
  AST_WAKE_MODE: assert property (wake_request |-> low_pwr)
    else $error("wake outside sleep or idle");
  AST_WAKE_GIVEN: assert property (conv_irq_flag_set && conv_irq_enable && low_pwr && $stable(low_pwr)
    |-> wake_request) else $error("enabled flag in low power without wake");
  AST_FLAG_PULSE: assert property (conv_irq_flag_set |=> !conv_irq_flag_set)
    else $error("flag pulse too long");
  AST_SLEEP_ABORT: assert property (sleep_mode && !conv_clk_run |-> ##[0:2] !conv_busy)
    else $error("conversion kept in sleep without clock");
  AST_SLEEP_NOFLAG: assert property ((sleep_mode && !conv_clk_run) [*3] |-> !conv_irq_flag_set)
    else $error("flag while clock stopped");
  AST_SLEEP_REGS: assert property ($rose(sleep_mode) || $fell(sleep_mode) |-> $stable(analog_pin_select))
    else $error("register changed on sleep edge");
  AST_RST_REGS: assert property (rst_s |=> analog_pin_select == 32'h0000_0000 && !conv_busy)
    else $error("reset left state");
  AST_RST_NOSTORE: assert property (rst_s |=> !conv_irq_flag_set ##1 !conv_irq_flag_set)
    else $error("result completed after reset");
  AST_READ_WAIT: assert property (hsel && htrans[1] && hready && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read answer timing");
  cover property (wake_request && sleep_mode);
  cover property (wake_request && idle_mode);
  cover property (rst_s && conv_busy);
  cover property (conv_irq_flag_set && !conv_irq_enable);
endmodule
bind adc_power_reset_control adc_power_reset_control_assertions #(.CONV_TADS(CONV_TADS), .RC_DIV(RC_DIV)) u_chk (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hreadyout(hreadyout), .external_pin_reset(external_pin_reset), .watchdog_reset_source(watchdog_reset_source),
  .sleep_mode(sleep_mode), .idle_mode(idle_mode), .conv_irq_enable(conv_irq_enable),
  .conv_irq_flag_set(conv_irq_flag_set), .wake_request(wake_request), .conv_clk_run(conv_clk_run),
  .conv_busy(conv_busy), .analog_pin_select(analog_pin_select));
`default_nettype wire

// [test/power_mode_model.sv]
// Power-mode manager model: enters SLEEP or IDLE on request, leaves on a wake request
`timescale 1ns/1ps
`default_nettype none
module power_mode_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic sleep_req,
  input wire logic idle_req,
  input wire logic wake_request,
  output logic sleep_mode,
  output logic idle_mode
);
  logic woke_r;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      woke_r <= 1'b0;
      sleep_mode <= 1'b0;
      idle_mode <= 1'b0;
    end else begin
      woke_r <= (woke_r || wake_request) && (sleep_req || idle_req);
      sleep_mode <= sleep_req && !woke_r && !wake_request;
      idle_mode <= idle_req && !woke_r && !wake_request;
    end
  end
endmodule
`default_nettype wire

// [test/tb.sv]
// Self-checking bench for the converter control block
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, ext_rst = 0, wdt_rst = 0;
  logic sleep_req = 0, idle_req = 0, debug_mode = 0, irq_en = 0, busy_s, clk_s;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, q, apsel;
  logic [9:0] code = 0;
  logic hready, hresp, flag_set, wake, clk_run, busy, sleep_mode, idle_mode;
  int error_cnt = 0, cmp_count = 0, flags = 0, wakes = 0, seed = 89573, n0, nf, nw;
  int mdl [6];
  always #2.5 hclk = ~hclk;
  adc_power_reset_control #(.CONV_TADS(4), .RC_DIV(2)) DUT (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hresp(hresp), .hrdata(hrdata),
    .external_pin_reset(ext_rst), .watchdog_reset_source(wdt_rst), .sleep_mode(sleep_mode),
    .idle_mode(idle_mode), .debug_mode(debug_mode), .conv_irq_enable(irq_en), .analog_code(code),
    .conv_irq_flag_set(flag_set), .wake_request(wake), .conv_clk_run(clk_run), .conv_busy(busy),
    .analog_pin_select(apsel));
  power_mode_model u_pm (.hclk(hclk), .hresetn(hresetn), .sleep_req(sleep_req), .idle_req(idle_req),
    .wake_request(wake), .sleep_mode(sleep_mode), .idle_mode(idle_mode));
  always @(negedge hclk) begin
    flags += (flag_set === 1'b1);
    wakes += (wake === 1'b1);
    busy_s = busy;
    clk_s = clk_run;
  end
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(negedge hclk); while (hready !== 1'b1);
    @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(negedge hclk); while (hready !== 1'b1);
    q = hrdata;
    @(posedge hclk);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), e, q);
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask
  task automatic allzero;
    for (int i = 0; i < 22; i++) rdchk(i < 6 ? 8'(4 * i) : 8'(4 * i + 40), 32'h0);
  endtask
  task automatic cfg(input logic [31:0] two, input logic [31:0] three);
    bus(1'b1, 8'h04, two);
    bus(1'b1, 8'h08, three);
    mdl[1] = two;
    mdl[2] = three;
  endtask
  task automatic start(input logic [31:0] base);
    code <= 10'($random(seed));
    bus(1'b1, 8'h00, base | 32'h0000_0002);
    bus(1'b1, 8'h00, base);
  endtask
  task automatic wait_flag;
    n0 = flags;
    repeat (4000) if (flags == n0) @(posedge hclk);
    @(posedge hclk);
    chk("flag pulse", 1, flags != n0);
  endtask
  initial begin
    repeat (40000) @(posedge hclk);
    error_cnt++;
    summarize();
  end
  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    allzero();
    for (int i = 1; i < 6; i++) begin
      mdl[i] = $random(seed);
      bus(1'b1, 8'(4 * i), mdl[i]);
    end
    bus(1'b1, 8'h30, 32'hFFFF_FFFF);
    hsize <= 3'h0;
    bus(1'b1, 8'h0C, 32'hFFFF_FFFF);
    hsize <= 3'h2;
    rdchk(8'h30, 32'h0);
    for (int i = 1; i < 6; i++) rdchk(8'(4 * i), mdl[i]);
    chk("pin select", mdl[4], apsel);
    for (int m = 0; m < 2; m++) begin
      cfg(32'h0, 32'h0000_00FF);
      nf = flags;
      start(m ? 32'h0000_A000 : 32'h0000_8000);
      repeat (20) @(posedge hclk);
      if (m) idle_req <= 1'b1;
      else sleep_req <= 1'b1;
      repeat (4) @(posedge hclk);
      if (!m) chk("clock run", 1'b0, clk_s);
      chk("busy", 1'b0, busy_s);
      sleep_req <= 1'b0;
      idle_req <= 1'b0;
      repeat (1200) @(posedge hclk);
      chk("flags", nf, flags);
      for (int i = 1; i < 6; i++) rdchk(8'(4 * i), mdl[i]);
    end
    for (int m = 0; m < 3; m++) begin
      cfg(32'h0, m == 1 ? 32'h0000_0103 : 32'h0000_8103);
      code <= 10'($random(seed));
      irq_en <= (m != 2);
      nw = wakes;
      bus(1'b1, 8'h00, 32'h0000_80E4);
      if (m == 1) idle_req <= 1'b1;
      else sleep_req <= 1'b1;
      repeat (3) @(posedge hclk);
      chk("clock run", 1'b1, clk_s);
      wait_flag();
      chk("wake", nw + (m != 2), wakes);
      if (m == 2) begin
        nf = flags;
        repeat (100) @(posedge hclk);
        chk("busy", 1'b0, busy_s);
        chk("flags", nf, flags);
        bus(1'b0, 8'h00, 32'h0);
        chk("on bit", 32'h0000_8001, q & 32'h0000_8001);
      end
      sleep_req <= 1'b0;
      idle_req <= 1'b0;
      bus(1'b1, 8'h00, 32'h0);
      rdchk(8'h40, {22'h0, code});
    end
    cfg(32'h0, 32'h0000_00FF);
    bus(1'b1, 8'h00, 32'h0000_4000);
    rdchk(8'h00, 32'h0);
    debug_mode <= 1'b1;
    bus(1'b1, 8'h00, 32'h0000_4000);
    rdchk(8'h00, 32'h0);
    debug_mode <= 1'b0;
    nf = flags;
    start(32'h0000_8000);
    repeat (20) @(posedge hclk);
    debug_mode <= 1'b1;
    repeat (4) @(posedge hclk);
    chk("busy", 1'b0, busy_s);
    rdchk(8'h00, 32'h0000_C000);
    bus(1'b1, 8'h04, 32'h0000_0010);
    rdchk(8'h04, 32'h0);
    debug_mode <= 1'b0;
    repeat (1200) @(posedge hclk);
    rdchk(8'h04, 32'h0000_0010);
    rdchk(8'h00, 32'h0000_8000);
    chk("flags", nf, flags);
    for (int s = 0; s < 2; s++) begin
      cfg(s ? 32'h0000_0004 : 32'h0, 32'h0000_0003);
      bus(1'b1, 8'h10, 32'h0000_FFFF);
      nf = flags;
      start(32'h0000_8000);
      if (s) begin
        repeat (100) @(posedge hclk);
        chk("flags", nf, flags);
        start(32'h0000_8000);
      end
      wait_flag();
      rdchk(8'h40 + 8'(4 * s), {22'h0, code});
      start(32'h0000_8000);
      nf = flags;
      if (s) wdt_rst <= 1'b1;
      else ext_rst <= 1'b1;
      @(posedge hclk);
      wdt_rst <= 1'b0;
      ext_rst <= 1'b0;
      repeat (100) @(posedge hclk);
      chk("flags", nf, flags);
      chk("busy", 1'b0, busy_s);
      chk("pin select", 32'h0, apsel);
      allzero();
    end
    summarize();
  end
endmodule
`default_nettype wire
